//--- rtl/spi_queue_dev.sv
`timescale 1ns/10ps
`default_nettype none
module spi_queue_dev
  import spi_queue_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  wb_adr_i,
  input  wire logic [7:0]  wb_dat_i,
  output logic      [7:0]  wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic        wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  output logic             err_irq_o,
  output logic             rx_irq_o,
  output logic             pins_owned_o,
  spi_link_if.dev          link
);
  import spi_queue_pkg::*;

  typedef enum logic {IDLE, SHIFT} phase_t;
  typedef struct packed {
    logic [2:0] sck_s, ss_s;
    logic [1:0] mi_s, mo_s;
    logic [7:0] ctl, st, txbuf, shreg, rxreg;
    logic [2:0] cnt;
    logic       edge2;
    logic       last_sck;
    logic [7:0] div;
    phase_t     ph;
    logic       sck_out;
    logic       st_seen_ovf, st_seen_mode_fault_flag;
    logic       ack;
    logic [7:0] rdat;
  } state_t;

  state_t q, d;
  logic en, mst, cpha, cpol, access, ss_low, sck_now, sck_prev;
  logic lead, trail, samp, shft, done, mode_fault_flag_cond;
  logic [7:0] rx_word;

  always_comb begin
    d      = q;
    en     = q.ctl[CTL_IF_EN];
    mst    = q.ctl[CTL_MASTER] & en;
    cpha   = q.ctl[CTL_CPHA];
    cpol   = q.ctl[CTL_CPOL];
    access = wb_cyc_i & wb_stb_i & ~q.ack;
    d.ack  = access;
    d.sck_s = {q.sck_s[1:0], link.sck_i};
    d.ss_s  = {q.ss_s[1:0], link.ss_n};
    d.mi_s  = {q.mi_s[0], link.miso_i};
    d.mo_s  = {q.mo_s[0], link.mosi_i};
    ss_low   = ~q.ss_s[1];
    sck_now  = q.sck_s[1] ^ cpol;
    sck_prev = q.sck_s[2] ^ cpol;
    samp = 1'b0;
    shft = 1'b0;
    done = 1'b0;
    mode_fault_flag_cond = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    rx_word = q.shreg;
    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    if (mst) begin
      if (q.ph == IDLE) begin
        if (!q.st[ST_TX_EMPTY]) begin
          d.shreg = q.txbuf;
          d.st[ST_TX_EMPTY] = 1'b1;
          d.ph = SHIFT;
          d.cnt = '0;
          d.div = '0;
          d.edge2 = 1'b0;
          d.sck_out = 1'b0;
        end
      end else if (q.div == 8'(HALF_CYC - 1)) begin
        d.div = '0;
        d.sck_out = ~q.sck_out;
        lead = ~q.sck_out;
        samp = lead ^ cpha;
        // phase 1: the first leading edge only starts the frame
        shft = (~lead ^ cpha) & ~(cpha & lead & (q.cnt == '0));
        if (!lead && q.cnt == LAST_BIT)
          done = 1'b1;
        else if (!lead)
          d.cnt = q.cnt + 3'h1;
      end else
        d.div = q.div + 8'h01;
      if (q.ss_s[2] & ~q.ss_s[1])
        mode_fault_flag_cond = 1'b1;
    end else if (en) begin
      lead  = sck_now & ~sck_prev;
      trail = ~sck_now & sck_prev;
      if (q.ss_s[1]) begin
        // deselected: clock edges ignored, transfer dropped
        if (q.ph == SHIFT)
          mode_fault_flag_cond = 1'b1;
        d.ph = IDLE;
        if (!q.st[ST_TX_EMPTY]) begin
          d.shreg = q.txbuf;
          d.st[ST_TX_EMPTY] = 1'b1;
        end
      end else if (q.ph == IDLE) begin
        // phase 0 starts only on the select edge, else a finished
        // frame would restart at once while select is still low
        if ((!cpha && q.ss_s[2]) || (cpha && lead)) begin
          d.ph = SHIFT;
          d.cnt = '0;
          if (!q.st[ST_TX_EMPTY]) begin
            d.shreg = q.txbuf;
            d.st[ST_TX_EMPTY] = 1'b1;
          end
          samp = ~cpha & lead;
        end else if (!q.st[ST_TX_EMPTY]) begin
          d.shreg = q.txbuf;
          d.st[ST_TX_EMPTY] = 1'b1;
        end
      end else begin
        // a busy slave leaves the queued byte in txbuf
        samp = cpha ? trail : lead;
        shft = cpha ? lead : trail;
        if (trail && q.cnt == LAST_BIT)
          done = 1'b1; // clock back at idle after last bit
        else if (trail)
          d.cnt = q.cnt + 3'h1;
      end
    end
    if (samp) begin
      d.last_sck = mst ? q.mi_s[1] : q.mo_s[1];
      if (q.cnt == OVF_STROBE_BIT && q.st[ST_RX_FULL])
        d.st[ST_OVERFLOW] = 1'b1;
    end
    if (shft)
      d.shreg = {q.shreg[6:0], q.last_sck};
    if (done) begin
      d.ph = IDLE;
      // the last edge either shifted or sampled; take the word as it
      // stands after that edge
      rx_word = shft ? d.shreg : {q.shreg[6:0], d.last_sck};
      d.shreg = rx_word; // received byte goes out next if no write
      if (!q.st[ST_OVERFLOW] && !d.st[ST_OVERFLOW]) begin
        d.rxreg = rx_word;
        d.st[ST_RX_FULL] = 1'b1;
      end
    end
    // ------------------------------------------------------------
    // mode fault
    // ------------------------------------------------------------
    if (mode_fault_flag_cond && q.st[ST_MODE_FAULT_FLAG_EN]) begin
      d.st[ST_MODE_FAULT] = 1'b1;
      if (mst) begin
        d.ctl[CTL_IF_EN] = 1'b0;
        d.st[ST_TX_EMPTY] = 1'b1;
        d.cnt = '0;
        d.ph = IDLE;
      end
    end
    if (!en) begin
      d.ph = IDLE;
      d.cnt = '0;
      d.shreg = '0;
      d.st[ST_TX_EMPTY] = 1'b1;
    end
    // ------------------------------------------------------------
    // register access, single-cycle ack
    // ------------------------------------------------------------
    if (access) begin
      unique case (wb_adr_i)
        REG_STATUS: begin
          d.rdat = q.st;
          if (!wb_we_i) begin
            d.st_seen_ovf  = q.st[ST_OVERFLOW];
            d.st_seen_mode_fault_flag = q.st[ST_MODE_FAULT];
          end else if (wb_sel_i) begin
            d.st[ST_MODE_FAULT_FLAG_EN] = wb_dat_i[ST_MODE_FAULT_FLAG_EN];
            d.st[ST_ERR_IE]  = wb_dat_i[ST_ERR_IE];
          end
        end
        REG_CONTROL: begin
          d.rdat = q.ctl;
          if (wb_we_i && wb_sel_i) begin
            d.ctl = wb_dat_i;
            if (q.st_seen_mode_fault_flag && !mode_fault_flag_cond)
              d.st[ST_MODE_FAULT] = 1'b0;
            d.st_seen_mode_fault_flag = 1'b0;
          end
        end
        REG_DATA: begin
          d.rdat = q.rxreg;
          if (wb_we_i && wb_sel_i) begin
            d.txbuf = wb_dat_i;
            d.st[ST_TX_EMPTY] = 1'b0;
          end else if (!wb_we_i) begin
            if (!d.st[ST_OVERFLOW] || q.st_seen_ovf) begin
              d.st[ST_RX_FULL] = done & ~q.st[ST_OVERFLOW];
            end
            if (q.st_seen_ovf && !(samp && d.st[ST_OVERFLOW] &&
                !q.st[ST_OVERFLOW]))
              d.st[ST_OVERFLOW] = 1'b0;
            d.st_seen_ovf = 1'b0;
          end
        end
        default: d.rdat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctl <= CTL_RESET;
      q.st <= ST_RESET;
      q.sck_s <= 3'h7;
      q.ss_s <= 3'h7;
    end else
      q <= d;
  end

  assign wb_ack_o     = q.ack;
  assign wb_dat_o     = q.rdat;
  assign rx_irq_o     = q.st[ST_RX_FULL] & ~q.ctl[CTL_DMA_SEL];
  assign err_irq_o    = q.st[ST_ERR_IE] &
                        (q.st[ST_OVERFLOW] | q.st[ST_MODE_FAULT]);
  assign pins_owned_o = q.ctl[CTL_IF_EN];
  assign link.sck_o     = q.sck_out ^ q.ctl[CTL_CPOL];
  assign link.sck_oe_n  = ~(q.ctl[CTL_IF_EN] & q.ctl[CTL_MASTER]);
  assign link.mosi_o    = q.shreg[7];
  assign link.mosi_oe_n = ~(q.ctl[CTL_IF_EN] & q.ctl[CTL_MASTER]);
  assign link.miso_o    = q.shreg[7];
  assign link.miso_oe_n = ~(q.ctl[CTL_IF_EN] & ~q.ctl[CTL_MASTER] &
                            ~q.ss_s[1]);
  // slave faults above touch only the flag
endmodule
`default_nettype wire

//--- rtl/spi_queue_pkg.sv
package spi_queue_pkg;
  localparam int          BITS_PER_FRAME = 8;
  localparam logic [2:0]  LAST_BIT       = 3'h7;
  localparam logic [2:0]  OVF_STROBE_BIT = 3'h6;
  localparam logic [1:0]  REG_STATUS     = 2'h0;
  localparam logic [1:0]  REG_CONTROL    = 2'h1;
  localparam logic [1:0]  REG_DATA       = 2'h2;
  localparam int          CTL_IF_EN      = 0;
  localparam int          CTL_MASTER     = 1;
  localparam int          CTL_CPHA       = 2;
  localparam int          CTL_CPOL       = 3;
  localparam int          CTL_DMA_SEL    = 4;
  localparam int          ST_MODE_FAULT_FLAG_EN     = 0;
  localparam int          ST_ERR_IE      = 1;
  localparam int          ST_RX_FULL     = 4;
  localparam int          ST_OVERFLOW    = 5;
  localparam int          ST_MODE_FAULT  = 6;
  localparam int          ST_TX_EMPTY    = 7;
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [7:0]  ST_RESET       = 8'h80;
  localparam int          HALF_BIT_CYC   = 4;
endpackage

//--- rtl/spi_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
  logic sck_o;
  logic sck_oe_n;
  logic sck_i;
  logic mosi_o;
  logic mosi_oe_n;
  logic mosi_i;
  logic miso_o;
  logic miso_oe_n;
  logic miso_i;
  logic ss_n;
  modport dev (
    output sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n,
    input  sck_i, mosi_i, miso_i, ss_n
  );
  modport far (
    input  sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n,
    output sck_i, mosi_i, miso_i, ss_n
  );
endinterface
`default_nettype wire

//--- rtl/spi_queue_far.sv
`timescale 1ns/10ps
`default_nettype none
module spi_queue_far
  import spi_queue_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       cpha_i,
  input  wire logic       cpol_i,
  input  wire logic [7:0] tx_i,
  output logic      [7:0] rx_o,
  output logic            done_o,
  output logic            busy_o,
  spi_link_if.far         link
);
  import spi_queue_pkg::*;

  typedef enum logic [1:0] {IDLE, SEL, RUN, DESEL} phase_t;
  typedef struct packed {
    phase_t     ph;
    logic [7:0] div, sh, rx;
    logic [4:0] edges;
    logic       sck, ss_n, done;
    logic [1:0] mi_s;
  } state_t;
  state_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.mi_s = {q.mi_s[0], link.miso_o};
    unique case (q.ph)
      IDLE: if (start_i) begin
        d.ph = SEL;
        d.sh = tx_i;
        d.ss_n = 1'b0;
        d.div = '0;
        d.edges = '0;
      end
      SEL, RUN: if (q.div == 8'(HALF_CYC - 1)) begin
        d.div = '0;
        d.ph = RUN;
        if (q.edges == 5'(2 * BITS_PER_FRAME))
          d.ph = DESEL;
        else begin
          d.sck = ~q.sck;
          d.edges = q.edges + 5'h01;
          if (q.edges[0] == cpha_i)
            d.rx = {q.rx[6:0], q.mi_s[1]};
          // msb is already on the line before the first edge
          else if (q.edges != 5'h00)
            d.sh = {q.sh[6:0], 1'b0};
        end
      end else
        d.div = q.div + 8'h01;
      DESEL: begin
        d.ss_n = 1'b1;
        d.done = 1'b1;
        d.ph = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ss_n <= 1'b1;
    end else
      q <= d;
  end

  assign link.sck_i  = q.sck ^ cpol_i;
  assign link.mosi_i = q.sh[7];
  assign link.miso_i = q.sh[7];
  assign link.ss_n   = q.ss_n;
  assign rx_o        = q.rx;
  assign done_o      = q.done;
  assign busy_o      = q.ph != IDLE;
endmodule
`default_nettype wire

//--- dv/spi_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module spi_link_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic sck_i,
  input wire logic ss_n
);
  logic       sck_q;
  logic [4:0] edges_q;
  // ------------------------------------------------------------
  // far clock edges inside one select window
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    sck_q <= sck_i;
    if (rst_i || ss_n) begin
      edges_q <= 5'h00;
    end else if (sck_i != sck_q) begin
      edges_q <= edges_q + 5'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_miso_float: assert property (ss_n [*4] |-> miso_oe_n)
    else $error("miso driven while deselected");
  a_float_quick: assert property ($rose(ss_n) |-> ##[1:4] miso_oe_n)
    else $error("miso not released after deselect");
  a_master_pins: assert property (!sck_oe_n |-> !mosi_oe_n && miso_oe_n)
    else $error("master pin directions wrong");
  a_mosi_master: assert property (!mosi_oe_n |-> !sck_oe_n)
    else $error("mosi driven without clock");
  a_slave_pins: assert property (!miso_oe_n |-> sck_oe_n && mosi_oe_n)
    else $error("slave pin directions wrong");
  a_frame_hold: assert property ($fell(ss_n) |-> !ss_n [*8])
    else $error("select window too short");
  a_frame_edges: assert property ($rose(ss_n) |-> edges_q == 5'h10)
    else $error("frame edge count not sixteen");
  a_reset_float: assert property ($fell(rst_i) |->
    sck_oe_n && mosi_oe_n && miso_oe_n)
    else $error("pins driven after reset");
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spi_queue_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0;
  logic        stb = 1'b0, start = 1'b0, cpha = 1'b0, cpol = 1'b0;
  logic        ack, err_irq, rx_irq, owned, done, busy;
  logic [1:0]  adr = 2'h0;
  logic [7:0]  wd = 8'h00, ftx = 8'h00, rd, frx, q, d, f;
  logic [31:0] seed = 32'h00008665;
  int          err_count = 0, tests_run = 0;
  spi_link_if lnk ();
  // half bit of 8 leaves room for both two-stage synchronisers
  spi_queue_dev #(.HALF_CYC(8)) i_spi_queue_dev (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .err_irq_o(err_irq),
    .rx_irq_o(rx_irq), .pins_owned_o(owned), .link(lnk));
  spi_queue_far #(.HALF_CYC(8)) i_spi_queue_far (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .cpha_i(cpha),
    .cpol_i(cpol), .tx_i(ftx), .rx_o(frx), .done_o(done),
    .busy_o(busy), .link(lnk));
  spi_link_asserts i_spi_link_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .sck_oe_n(lnk.sck_oe_n),
    .mosi_oe_n(lnk.mosi_oe_n), .miso_oe_n(lnk.miso_oe_n),
    .sck_i(lnk.sck_i), .ss_n(lnk.ss_n));
  always #12.5 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // status bits 3:2 are not specified, so they are masked out
  function automatic logic [7:0] stat(input logic te, mf, ov, rf, me);
    return {te, mf, ov, rf, 2'b00, 1'b1, me};
  endfunction
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      err_count++;
    end
  endtask
  task automatic wb(input logic [1:0] a, input logic w, input logic [7:0] v);
    int n;
    n = 0;
    adr <= a;
    we  <= w;
    wd  <= v;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) err_count++;
    @(posedge clk_i);
  endtask
  task automatic st(input logic [7:0] e);
    wb(REG_STATUS, 1'b0, 8'h00);
    chk(q & 8'hf3, e);
  endtask
  // far master runs one whole frame, then the slave gets time to settle
  task automatic frame(input logic [7:0] v);
    int n;
    n = 0;
    ftx   <= v;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) err_count++;
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(REG_STATUS, 1'b0, 8'h00);
    chk(q, ST_RESET);
    wb(REG_CONTROL, 1'b0, 8'h00);
    chk(q, CTL_RESET);
    wb(2'h3, 1'b1, 8'h5a);
    wb(2'h3, 1'b0, 8'h00);
    chk(q, 8'h00);
    wb(REG_STATUS, 1'b1, 8'h03);
    for (int i = 0; i < 4; i++) begin
      cpha <= i[0];
      cpol <= i[1];
      wb(REG_CONTROL, 1'b1, {4'h0, i[1], i[0], 2'b00});
      wb(REG_CONTROL, 1'b1, {4'h0, i[1], i[0], 2'b01});
      d = (i == 0) ? 8'h80 : rnd();
      f = (i == 3) ? 8'hff : rnd();
      wb(REG_DATA, 1'b1, d);
      st(stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
      frame(f);
      chk(frx, d);
      st(stat(1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
      chk({7'h00, rx_irq}, 8'h01);
      wb(REG_DATA, 1'b0, 8'h00);
      chk(q, f);
      d = f;
      f = rnd();
      frame(f);
      chk(frx, d);
      st(stat(1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
      wb(REG_DATA, 1'b0, 8'h00);
      chk(q, f);
      st(stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
    end
    f = rnd();
    frame(f);
    frame(rnd());
    st(stat(1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    chk({7'h00, err_irq}, 8'h01);
    wb(REG_DATA, 1'b0, 8'h00);
    chk(q, f);
    st(stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
    chk({7'h00, err_irq}, 8'h00);
    wb(REG_CONTROL, 1'b1, 8'h02);
    wb(REG_CONTROL, 1'b1, 8'h03);
    chk({7'h00, owned}, 8'h01);
    frame(8'h3c);
    st(stat(1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
    chk({7'h00, err_irq}, 8'h01);
    chk({7'h00, owned}, 8'h00);
    wb(REG_CONTROL, 1'b0, 8'h00);
    chk(q, 8'h02);
    wb(REG_CONTROL, 1'b1, 8'h00);
    st(stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
    wb(REG_STATUS, 1'b1, 8'h02);
    wb(REG_CONTROL, 1'b1, 8'h03);
    frame(8'hc3);
    st(stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    wb(REG_CONTROL, 1'b0, 8'h00);
    chk(q, 8'h03);
    give_verdict();
  end
endmodule
`default_nettype wire
